/* File: acr_config_bank.sv */
// Upper configuration register bank of a dual converter
`timescale 1ns/10ps
`include "acr_regs.svh"
module acr_config_bank
  import acr_pkg::*;
#(
  parameter logic [2:0] DEFAULT_GRADE = 3'h5
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          clkEn,
  input  wire acr_req_t      req,
  input  wire logic [15:0]   sigValue,
  input  wire logic          sigValid,
  input  wire logic          syncPulse,
  input  wire logic          outEnableLowPin,
  input  wire logic          overrangeIn,
  output logic [7:0]         rdata,
  output logic [2:0]         fullScaleSel,
  output logic [15:0]        userPatternOne,
  output logic [15:0]        userPatternTwo,
  output logic               overrangeOut,
  output logic               chanASelB,
  output logic               chanBSelB,
  output logic               dividerSync,
  output acr_rate_cfg_t      rateCfg,
  output logic               chipPowerDown,
  output logic               outputsDisabled,
  output logic               dataPullDownOn,
  output logic               commonModePowerDown
);
  logic [7:0]  refReg, refNext, p1lReg, p1lNext, p1hReg, p1hNext;
  logic [7:0]  p2lReg, p2lNext, p2hReg, p2hNext, ovrReg, ovrNext;
  logic [7:0]  asgAReg, asgANext, asgBReg, asgBNext, syncReg, syncNext;
  logic [7:0]  rateReg, rateNext, uio2Reg, uio2Next, uio3Reg, uio3Next;
  logic [15:0] sigReg, sigNext;
  acr_rate_cfg_t rateCfgNext;
  logic [7:0]  rdNext;
  logic        syncOutNext, ovrOutNext, pdNext, oeDisNext;
  logic        wr;

  // Channel B copy of output assign is kept alongside channel A at one address
  always_comb begin
    wr       = req.write && clkEn;
    refNext  = refReg;
    p1lNext  = p1lReg;
    p1hNext  = p1hReg;
    p2lNext  = p2lReg;
    p2hNext  = p2hReg;
    ovrNext  = ovrReg;
    asgANext = asgAReg;
    asgBNext = asgBReg;
    syncNext = syncReg;
    rateNext = rateReg;
    uio2Next = uio2Reg;
    uio3Next = uio3Reg;
    sigNext  = sigValid ? sigValue : sigReg;
    rateCfgNext = rateCfg;
    if (wr) begin
      if (req.addr == `ACR_ADDR_REF_SEL) begin
        refNext = req.wdata & `ACR_MASK_REF_SEL;
      end else if (req.addr == `ACR_ADDR_PAT1_LO) begin
        p1lNext = req.wdata;
      end else if (req.addr == `ACR_ADDR_PAT1_HI) begin
        p1hNext = req.wdata;
      end else if (req.addr == `ACR_ADDR_PAT2_LO) begin
        p2lNext = req.wdata;
      end else if (req.addr == `ACR_ADDR_PAT2_HI) begin
        p2hNext = req.wdata;
      end else if (req.addr == `ACR_ADDR_OVR_CTL) begin
        ovrNext = req.wdata & `ACR_MASK_OVR_CTL;
      end else if (req.addr == `ACR_ADDR_OUT_ASSIGN) begin
        asgANext = req.wdata & `ACR_MASK_ASSIGN;
        asgBNext = req.wdata & `ACR_MASK_ASSIGN;
      end else if (req.addr == `ACR_ADDR_SYNC_CTL) begin
        syncNext = req.wdata & `ACR_MASK_SYNC;
      end else if (req.addr == `ACR_ADDR_RATE_OVR) begin
        rateNext = req.wdata & `ACR_MASK_RATE;
      end else if (req.addr == `ACR_ADDR_UIO_TWO) begin
        uio2Next = req.wdata & `ACR_MASK_UIO_TWO;
      end else if (req.addr == `ACR_ADDR_UIO_THREE) begin
        uio3Next = req.wdata & `ACR_MASK_UIO_THREE;
      end else if (req.addr == `ACR_ADDR_TRANSFER &&
                   req.wdata[`ACR_BIT_XFER]) begin
        // Commit shadow copy; later override writes wait for next transfer
        rateCfgNext.enable     = rateReg[`ACR_BIT_RATE_EN];
        rateCfgNext.resolution = rateReg[5:3];
        rateCfgNext.rate       = rateReg[2:0];
      end
    end
    // With next-only set, self-clear after the first gated pulse; a host write loses to it
    syncOutNext = syncPulse && syncReg[`ACR_BIT_SYNC_EN];
    if (syncOutNext && syncReg[`ACR_BIT_SYNC_NEXT]) begin
      syncNext[`ACR_BIT_SYNC_EN] = 1'b0;
    end
    ovrOutNext = overrangeIn && ovrReg[0];
    // Rate codes rise with speed, so a larger code is an upgrade
    pdNext    = rateCfgNext.enable &&
                (rateCfgNext.rate > DEFAULT_GRADE);
    oeDisNext = outEnableLowPin && uio2Reg[`ACR_BIT_OEB_EN];
    rdNext = 8'h00;
    if (req.addr == `ACR_ADDR_REF_SEL) begin
      rdNext = refReg;
    end else if (req.addr == `ACR_ADDR_PAT1_LO) begin
      rdNext = p1lReg;
    end else if (req.addr == `ACR_ADDR_PAT1_HI) begin
      rdNext = p1hReg;
    end else if (req.addr == `ACR_ADDR_PAT2_LO) begin
      rdNext = p2lReg;
    end else if (req.addr == `ACR_ADDR_PAT2_HI) begin
      rdNext = p2hReg;
    end else if (req.addr == `ACR_ADDR_SIG_LO) begin
      rdNext = sigReg[7:0];
    end else if (req.addr == `ACR_ADDR_SIG_HI) begin
      rdNext = sigReg[15:8];
    end else if (req.addr == `ACR_ADDR_OVR_CTL) begin
      rdNext = ovrReg;
    end else if (req.addr == `ACR_ADDR_OUT_ASSIGN) begin
      rdNext = asgAReg;
    end else if (req.addr == `ACR_ADDR_SYNC_CTL) begin
      rdNext = syncReg;
    end else if (req.addr == `ACR_ADDR_RATE_OVR) begin
      rdNext = rateReg;
    end else if (req.addr == `ACR_ADDR_UIO_TWO) begin
      rdNext = uio2Reg;
    end else if (req.addr == `ACR_ADDR_UIO_THREE) begin
      rdNext = uio3Reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refReg  <= `ACR_RST_REF_SEL;
      p1lReg  <= 8'h00;
      p1hReg  <= 8'h00;
      p2lReg  <= 8'h00;
      p2hReg  <= 8'h00;
      ovrReg  <= `ACR_RST_OVR_CTL;
      asgAReg <= 8'h00;
      asgBReg <= 8'h01;
      syncReg <= 8'h00;
      rateReg <= 8'h00;
      uio2Reg <= 8'h00;
      uio3Reg <= 8'h00;
      sigReg  <= `ACR_RST_SIG;
      rateCfg <= '0;
      rdata   <= 8'h00;
      dividerSync     <= 1'b0;
      overrangeOut    <= 1'b0;
      chipPowerDown   <= 1'b0;
      outputsDisabled <= 1'b0;
      fullScaleSel    <= 3'h4;
      userPatternOne  <= 16'h0000;
      userPatternTwo  <= 16'h0000;
      chanASelB       <= 1'b0;
      chanBSelB       <= 1'b1;
      dataPullDownOn  <= 1'b1;
      commonModePowerDown <= 1'b0;
    end else if (clkEn) begin
      refReg  <= refNext;
      p1lReg  <= p1lNext;
      p1hReg  <= p1hNext;
      p2lReg  <= p2lNext;
      p2hReg  <= p2hNext;
      ovrReg  <= ovrNext;
      asgAReg <= asgANext;
      asgBReg <= asgBNext;
      syncReg <= syncNext;
      rateReg <= rateNext;
      uio2Reg <= uio2Next;
      uio3Reg <= uio3Next;
      sigReg  <= sigNext;
      rateCfg <= rateCfgNext;
      rdata   <= rdNext;
      dividerSync     <= syncOutNext;
      overrangeOut    <= ovrOutNext;
      chipPowerDown   <= pdNext;
      outputsDisabled <= oeDisNext;
      fullScaleSel    <= refNext[2:0];
      userPatternOne  <= {p1hNext, p1lNext};
      userPatternTwo  <= {p2hNext, p2lNext};
      chanASelB       <= asgANext[0];
      chanBSelB       <= asgBNext[0];
      dataPullDownOn  <= !uio2Next[`ACR_BIT_PD_OFF];
      commonModePowerDown <= uio3Next[`ACR_BIT_CM_PD];
    end
  end

  chk_overrange_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn && !ovrReg[0] |=> !overrangeOut)
    else $error("overrange output active while disabled");
  // After a frozen cycle the output dates from an older edge
  chk_sync_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(clkEn) && dividerSync |-> $past(syncReg[`ACR_BIT_SYNC_EN]))
    else $error("sync passed while disabled");
  chk_sync_once: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn && syncPulse && syncReg[2] && syncReg[1] && !wr
    |=> !syncReg[1])
    else $error("next-only sync did not clear enable");
  chk_rate_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn && !(wr && req.addr == `ACR_ADDR_TRANSFER) |=> $stable(rateCfg))
    else $error("override changed without transfer");
  chk_rate_commit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr && req.addr == `ACR_ADDR_TRANSFER && req.wdata[0]
    |=> rateCfg == $past(rateReg[6:0]))
    else $error("transfer did not commit override");
  // Power-down must always track the committed grade, frozen or not
  chk_power_down: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    chipPowerDown == (rateCfg.enable && rateCfg.rate > DEFAULT_GRADE))
    else $error("power-down does not match committed grade");
  chk_oeb_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(clkEn) && outputsDisabled |-> $past(uio2Reg[7]))
    else $error("pin honoured while disabled");
  chk_sig_ro: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn && !sigValid |=> $stable(sigReg))
    else $error("signature changed without update");
  chk_pattern_one: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> userPatternOne == {p1hReg, p1lReg})
    else $error("pattern one mismatch");
  cov_transfer: cover property (@(posedge sys_clk)
    wr && req.addr == `ACR_ADDR_TRANSFER);
  cov_sync_once: cover property (@(posedge sys_clk)
    syncPulse && syncReg[2] && syncReg[1]);
  cov_power_down: cover property (@(posedge sys_clk) chipPowerDown);
endmodule

/* File: acr_regs.svh */
// Register offsets, field positions, reset values and the rule contract
// Contract
// - Reference select bits 2:0 pick full scale 1.0 to 2.0 V; reset 0x04.
// - Pattern one: low byte bits 7:0, next byte bits 15:8; reset zero.
// - Pattern two: low byte bits 7:0, next byte bits 15:8; reset zero.
// - Overrange output driven only while overrange control bit 0 is one.
// - Output assign bit 0 routes converter A or B; A=0, B=1 defaults.
// - Rate override bits 5:3 give resolution 14/12/10 when bit 6 set.
// - Rate override bits 2:0 give 80/105/125 MSPS; reset means none.
// - Output-enable-low pin honoured only when I/O control two bit 7 set.
// - I/O control two bit 0 high switches off the data pin pull-down.
// - Sync pulses reach the clock divider only while sync enable is high.
// - With next-only set, align to first pulse then clear sync enable.
// - Writes act at once, except rate override, committed via transfer.
// - Override above default speed grade powers the device down.
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH
`define ACR_ADDR_REF_SEL    10'h018
`define ACR_ADDR_PAT1_LO    10'h019
`define ACR_ADDR_PAT1_HI    10'h01a
`define ACR_ADDR_PAT2_LO    10'h01b
`define ACR_ADDR_PAT2_HI    10'h01c
`define ACR_ADDR_SIG_LO     10'h024
`define ACR_ADDR_SIG_HI     10'h025
`define ACR_ADDR_OVR_CTL    10'h02a
`define ACR_ADDR_OUT_ASSIGN 10'h02e
`define ACR_ADDR_SYNC_CTL   10'h03a
`define ACR_ADDR_TRANSFER   10'h0ff
`define ACR_ADDR_RATE_OVR   10'h100
`define ACR_ADDR_UIO_TWO    10'h101
`define ACR_ADDR_UIO_THREE  10'h102
`define ACR_RST_REF_SEL     8'h04
`define ACR_RST_OVR_CTL     8'h01
`define ACR_RST_SIG         16'hffff
`define ACR_MASK_REF_SEL    8'h07
`define ACR_MASK_OVR_CTL    8'h01
`define ACR_MASK_ASSIGN     8'h01
`define ACR_MASK_SYNC       8'h06
`define ACR_MASK_RATE       8'h7f
`define ACR_MASK_UIO_TWO    8'h81
`define ACR_MASK_UIO_THREE  8'h08
`define ACR_BIT_SYNC_EN     1
`define ACR_BIT_SYNC_NEXT   2
`define ACR_BIT_RATE_EN     6
`define ACR_BIT_OEB_EN      7
`define ACR_BIT_PD_OFF      0
`define ACR_BIT_CM_PD       3
`define ACR_BIT_XFER        0
`endif

/* File: acr_pkg.sv */
// Types shared by the converter configuration register bank
package acr_pkg;
  typedef enum logic [2:0] {
    ACR_FS_1V00 = 3'h0,
    ACR_FS_1V14 = 3'h1,
    ACR_FS_1V33 = 3'h2,
    ACR_FS_1V60 = 3'h3,
    ACR_FS_2V00 = 3'h4
  } acr_fullscale_t;
  typedef enum logic [2:0] {
    ACR_RES_14 = 3'h2,
    ACR_RES_12 = 3'h4,
    ACR_RES_10 = 3'h6
  } acr_res_t;
  typedef enum logic [2:0] {
    ACR_RATE_80  = 3'h3,
    ACR_RATE_105 = 3'h4,
    ACR_RATE_125 = 3'h5
  } acr_rate_t;
  // Committed override as seen by the converter core
  typedef struct packed {
    logic       enable;
    logic [2:0] resolution;
    logic [2:0] rate;
  } acr_rate_cfg_t;
  typedef struct packed {
    logic       write;
    logic       read;
    logic [9:0] addr;
    logic [7:0] wdata;
  } acr_req_t;
endpackage

/* File: acr_host_model.sv */
// Host model issuing register writes and reads to the bank
`timescale 1ns/10ps
module acr_host_model
  import acr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] rdata,
  output acr_req_t        req
);
  initial req = '{write: 1'b0, read: 1'b0, addr: 10'h3ff, wdata: 8'h00};
  // Data bus scrambled after release so stale data never looks valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req.addr = a;
    req.wdata = d;
    req.write = 1'b1;
    @(negedge sys_clk);
    req.write = 1'b0;
    req.wdata = ~d;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    req.addr = a;
    @(negedge sys_clk);
    d = rdata;
  endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
`include "acr_regs.svh"
module tb_top
  import acr_pkg::*;
;
  logic          sys_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          clkEn = 1'b1;
  logic [15:0]   sigValue = 16'h0000;
  logic          sigValid = 1'b0;
  logic          syncPulse = 1'b0;
  logic          oePin = 1'b0;
  logic          ovrIn = 1'b1;
  acr_req_t      req;
  logic [7:0]    rdata;
  logic [2:0]    fs;
  logic [15:0]   patOne, patTwo;
  logic          ovrOut, selA, selB, divSync, chipPd, outDis, pullOn, cmPd;
  acr_rate_cfg_t rateCfg;
  int            n_errors = 0;
  int            compares = 0;
  logic [9:0]    addrTab [13] = '{10'h018, 10'h019, 10'h01a, 10'h01b,
    10'h01c, 10'h024, 10'h025, 10'h02a, 10'h02e, 10'h03a, 10'h100,
    10'h101, 10'h102};
  logic [7:0]    rstTab [13] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hff, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]    v, held;
  always #4 sys_clk = ~sys_clk;
  acr_host_model host_u (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  acr_config_bank dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .req(req), .sigValue(sigValue), .sigValid(sigValid),
    .syncPulse(syncPulse), .outEnableLowPin(oePin), .overrangeIn(ovrIn),
    .rdata(rdata), .fullScaleSel(fs), .userPatternOne(patOne),
    .userPatternTwo(patTwo), .overrangeOut(ovrOut), .chanASelB(selA),
    .chanBSelB(selB), .dividerSync(divSync), .rateCfg(rateCfg),
    .chipPowerDown(chipPd), .outputsDisabled(outDis),
    .dataPullDownOn(pullOn), .commonModePowerDown(cmPd));
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
  endtask
  // Sync is sampled per cycle, so the pulse lasts one enabled edge
  task automatic pulse(input logic e);
    @(negedge sys_clk);
    syncPulse = 1'b1;
    @(negedge sys_clk);
    chk("dividerSync", {15'h0, e}, {15'h0, divSync});
    syncPulse = 1'b0;
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 13; i++) rc(addrTab[i], rstTab[i]);
    chk("sel", 16'h1, {14'h0, selA, selB});
    chk("pull", 16'h1, {15'h0, pullOn});
    chk("ovr", 16'h1, {15'h0, ovrOut});
    // Enabled path must still follow the raw indication
    ovrIn = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("ovr", 16'h0, {15'h0, ovrOut});
    ovrIn = 1'b1;
    for (int k = 0; k < 5; k++) begin
      host_u.wr(`ACR_ADDR_REF_SEL, 8'hf8 | 8'(k));
      chk("fs", 16'(k), {13'h0, fs});
      rc(`ACR_ADDR_REF_SEL, 8'(k));
    end
    host_u.wr(`ACR_ADDR_PAT1_LO, 8'h34);
    host_u.wr(`ACR_ADDR_PAT1_HI, 8'h12);
    host_u.wr(`ACR_ADDR_PAT2_LO, 8'hcd);
    host_u.wr(`ACR_ADDR_PAT2_HI, 8'hab);
    chk("patOne", 16'h1234, patOne);
    chk("patTwo", 16'habcd, patTwo);
    // A write while the enable is low must leave pattern one alone
    clkEn = 1'b0;
    host_u.wr(`ACR_ADDR_PAT1_LO, 8'h77);
    clkEn = 1'b1;
    chk("patOne", 16'h1234, patOne);
    host_u.wr(`ACR_ADDR_OVR_CTL, 8'h00);
    chk("ovr", 16'h0, {15'h0, ovrOut});
    host_u.wr(`ACR_ADDR_OUT_ASSIGN, 8'h01);
    chk("sel", 16'h3, {14'h0, selA, selB});
    host_u.wr(10'h030, 8'hff);
    rc(10'h030, 8'h00);
    host_u.wr(`ACR_ADDR_SIG_LO, 8'h00);
    rc(`ACR_ADDR_SIG_LO, 8'hff);
    @(negedge sys_clk);
    sigValue = 16'h5a3c;
    sigValid = 1'b1;
    @(negedge sys_clk);
    sigValid = 1'b0;
    rc(`ACR_ADDR_SIG_LO, 8'h3c);
    rc(`ACR_ADDR_SIG_HI, 8'h5a);
    pulse(1'b0);
    host_u.wr(`ACR_ADDR_SYNC_CTL, 8'h02);
    pulse(1'b1);
    pulse(1'b1);
    host_u.wr(`ACR_ADDR_SYNC_CTL, 8'h06);
    pulse(1'b1);
    pulse(1'b0);
    rc(`ACR_ADDR_SYNC_CTL, 8'h04);
    // Committed value must stay at the previous one until the transfer
    held = 8'h00;
    for (int k = 0; k < 3; k++) begin
      v = 8'h40 | 8'((2 * k + 2) << 3) | 8'(k + 3);
      host_u.wr(`ACR_ADDR_RATE_OVR, v);
      host_u.wr(`ACR_ADDR_TRANSFER, 8'h00);
      chk("held", {8'h00, held}, {9'h0, rateCfg});
      host_u.wr(`ACR_ADDR_TRANSFER, 8'h01);
      chk("rateCfg", {8'h00, v}, {9'h0, rateCfg});
      chk("chipPd", 16'h0, {15'h0, chipPd});
      held = v;
    end
    host_u.wr(`ACR_ADDR_RATE_OVR, 8'h46);
    host_u.wr(`ACR_ADDR_TRANSFER, 8'h01);
    chk("chipPd", 16'h1, {15'h0, chipPd});
    // Give the pin time to reach the output before looking
    oePin = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("outDis", 16'h0, {15'h0, outDis});
    host_u.wr(`ACR_ADDR_UIO_TWO, 8'hff);
    chk("outDis", 16'h1, {15'h0, outDis});
    chk("pull", 16'h0, {15'h0, pullOn});
    rc(`ACR_ADDR_UIO_TWO, 8'h81);
    host_u.wr(`ACR_ADDR_UIO_THREE, 8'hff);
    chk("cmPd", 16'h1, {15'h0, cmPd});
    rc(`ACR_ADDR_UIO_THREE, 8'h08);
    print_verdict();
  end
endmodule
